/* File: dsm_pkg.sv */
// Shared constants and types for the drive sequencing state machine.
package dsm_pkg;

    // Register word indices on the Avalon-MM slave, taken from address bits 4:2.
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_CONFIG = 3'h2;
    localparam logic [2:0] REG_SPEED_REF = 3'h3;
    localparam logic [2:0] REG_ADJUST = 3'h4;
    localparam logic [2:0] REG_CFG_PARAM = 3'h5;
    localparam logic [2:0] REG_AUTOTUNE = 3'h6;
    localparam int ADDR_LSB = 2;

    // Control word field positions.
    localparam int CW_SWITCH_ON = 0;
    localparam int CW_EN_VOLTAGE = 1;
    localparam int CW_QUICK_STOP = 2;
    localparam int CW_EN_OPER = 3;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_HALT = 8;

    // Drive configuration field positions and reset value.
    localparam int CFG_DIS_OPT = 0;
    localparam int CFG_QS_HOLD = 1;
    localparam int CFG_CONTACTOR = 2;
    localparam int CFG_REF_CHANNEL = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;

    // Status word values reported for each visible state.
    localparam logic [15:0] SW_SW_ON_DIS = 16'h0040;
    localparam logic [15:0] SW_READY = 16'h0021;
    localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
    localparam logic [15:0] SW_OPER_EN = 16'h0027;
    localparam logic [15:0] SW_QUICK_STOP = 16'h0007;
    localparam logic [15:0] SW_FAULT = 16'h0008;
    localparam logic [15:0] SW_NOT_READY = 16'h0000;

    // Deceleration steps per clock for the normal and the fast ramp.
    localparam logic [15:0] RAMP_STEP = 16'h0001;
    localparam logic [15:0] FAST_STEP = 16'h0010;

    // Auto-tuning run time.
    localparam int TUNE_TIME_US = 100;
    localparam int CLK_MHZ = 25;
    localparam int TUNE_CYCLES = TUNE_TIME_US * CLK_MHZ;

    typedef enum logic [3:0] {
        ST_INIT,
        ST_SW_ON_DIS,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OPER_EN,
        ST_OPER_STOP,
        ST_QUICK_STOP,
        ST_FAULT
    } dsm_state_e;

    typedef enum logic [2:0] {
        CMD_DIS_VOLTAGE,
        CMD_QUICK_STOP,
        CMD_SHUTDOWN,
        CMD_SWITCH_ON,
        CMD_ENABLE_OP,
        CMD_NONE
    } dsm_cmd_e;

endpackage

/* File: dsm_ramp.sv */
// Speed ramp that decelerates the held speed to zero on a stop.
`timescale 1ns/1ps
module dsm_ramp
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic fast,
    input wire logic [15:0] speed_in,
    output logic done
);

    logic [15:0] speed_reg;
    logic [15:0] step;

    assign step = fast ? dsm_pkg::FAST_STEP : dsm_pkg::RAMP_STEP;
    assign done = (speed_reg == 16'h0000);

    // While not stopping the ramp follows the reference, so a stop starts from it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            speed_reg <= 16'h0000;
        else if (!run)
            speed_reg <= speed_in;
        else if (speed_reg > step)
            speed_reg <= speed_reg - step;
        else
            speed_reg <= 16'h0000;
    end

endmodule

/* File: dsm_top.sv */
// Drive sequencing state machine with its Avalon-MM register slave.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - Initialization state is never reported.
// - Switch-on-disabled: locked, unpowered, contactor off, writable.
// - Ready: unpowered; advances only with line supply.
// - Switched-on: contactor driven, supply required, no voltage.
// - Configuration write in switched-on returns to disabled.
// - Operation enabled: powered; configuration writes rejected.
// - Zero reference or halt removes motor power.
// - Auto-tuning runs only in operation enabled.
// - Enable needs valid channel and first reference.
// - Disable option zero: coast straight to switched-on.
// - Disable option one: ramp down, then switched-on.
// - Quick stop powered until its ramp ends; restart only via disabled.
// - Auto-exit option: fast ramp, then disabled.
// - Hold option: stay until disable, key, freewheel.
// - Status word identifies the state; the stop ramp reads as operation enabled.
// - Fault stays locked until a fault reset.
module dsm_top
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic LINE_SUPPLY_OK,
    input wire logic CHANNEL_VALID,
    input wire logic STOP_KEY,
    input wire logic FREEWHEEL_STOP,
    input wire logic FAULT_DETECTED,
    output logic MOTOR_POWER,
    output logic LINE_CONTACTOR,
    output logic DRIVE_UNLOCKED,
    output logic AUTOTUNE_ACTIVE,
    output logic [15:0] STATE_WORD
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Commands are decoded from single control word bits, checked in priority order.
    function automatic dsm_pkg::dsm_cmd_e decode_cmd(input logic [15:0] cw);
        if (!cw[dsm_pkg::CW_EN_VOLTAGE])
            return dsm_pkg::CMD_DIS_VOLTAGE;
        else if (!cw[dsm_pkg::CW_QUICK_STOP])
            return dsm_pkg::CMD_QUICK_STOP;
        else if (!cw[dsm_pkg::CW_SWITCH_ON])
            return dsm_pkg::CMD_SHUTDOWN;
        else if (!cw[dsm_pkg::CW_EN_OPER])
            return dsm_pkg::CMD_SWITCH_ON;
        else
            return dsm_pkg::CMD_ENABLE_OP;
    endfunction

    function automatic logic [15:0] merge_lanes(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0])
            res[7:0] = wd[7:0];
        if (be[1])
            res[15:8] = wd[15:8];
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register slave.

    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [15:0] control_reg;
    logic [3:0] config_reg;
    logic [15:0] speed_ref_reg;
    logic [15:0] adjust_reg;
    logic [15:0] cfg_param_reg;
    logic ref_seen_reg;
    logic fault_bit_reg;
    logic tune_busy_reg;
    logic [11:0] tune_cnt_reg;
    logic [15:0] state_word_reg;
    dsm_pkg::dsm_state_e state_reg;
    dsm_pkg::dsm_state_e state_next;
    dsm_pkg::dsm_cmd_e cmd;
    logic [2:0] reg_sel;
    logic wr_fire;
    logic cfg_wr;
    logic cfg_allowed;
    logic tune_start;
    logic ramp_run;
    logic ramp_done;
    logic fault_reset;
    logic qs_exit;
    logic ref_ready;

    assign reg_sel = AVS_ADDRESS[4:dsm_pkg::ADDR_LSB];
    // A write takes effect only at the edge where the master sees waitrequest low.
    assign wr_fire = AVS_WRITE && !wait_reg;
    assign cfg_wr = wr_fire && (reg_sel == dsm_pkg::REG_CFG_PARAM);
    assign cmd = decode_cmd(control_reg);

    // One wait cycle for every access keeps reads and writes alike.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            wait_reg <= 1'b1;
        else if ((AVS_READ || AVS_WRITE) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // Unmapped offsets read as zero.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            rdata_reg <= 32'h0000_0000;
        else if (AVS_READ && wait_reg)
        begin
            case (reg_sel)
                dsm_pkg::REG_CONTROL: rdata_reg <= {16'h0000, control_reg};
                dsm_pkg::REG_STATUS: rdata_reg <= {16'h0000, state_word_reg};
                dsm_pkg::REG_CONFIG: rdata_reg <= {28'h000_0000, config_reg};
                dsm_pkg::REG_SPEED_REF: rdata_reg <= {16'h0000, speed_ref_reg};
                dsm_pkg::REG_ADJUST: rdata_reg <= {16'h0000, adjust_reg};
                dsm_pkg::REG_CFG_PARAM: rdata_reg <= {16'h0000, cfg_param_reg};
                dsm_pkg::REG_AUTOTUNE: rdata_reg <= {31'h0000_0000, tune_busy_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            control_reg <= 16'h0000;
        else if (wr_fire && reg_sel == dsm_pkg::REG_CONTROL)
            control_reg <= merge_lanes(control_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            config_reg <= dsm_pkg::CFG_RESET;
        else if (wr_fire && reg_sel == dsm_pkg::REG_CONFIG && AVS_BYTEENABLE[0])
            config_reg <= AVS_WRITEDATA[3:0];
    end

    // The first reference written marks the channel as having supplied one.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            speed_ref_reg <= 16'h0000;
            ref_seen_reg <= 1'b0;
        end
        else if (wr_fire && reg_sel == dsm_pkg::REG_SPEED_REF)
        begin
            speed_ref_reg <= merge_lanes(speed_ref_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
            ref_seen_reg <= 1'b1;
        end
    end

    // Adjustment parameters may change in every state.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            adjust_reg <= 16'h0000;
        else if (wr_fire && reg_sel == dsm_pkg::REG_ADJUST)
            adjust_reg <= merge_lanes(adjust_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    // Configuration is frozen while the motor may be powered.
    assign cfg_allowed = (state_reg != dsm_pkg::ST_OPER_EN)
        && (state_reg != dsm_pkg::ST_OPER_STOP)
        && (state_reg != dsm_pkg::ST_QUICK_STOP);

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            cfg_param_reg <= 16'h0000;
        else if (cfg_wr && cfg_allowed)
            cfg_param_reg <= merge_lanes(cfg_param_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing.

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            fault_bit_reg <= 1'b0;
        else
            fault_bit_reg <= control_reg[dsm_pkg::CW_FAULT_RESET];
    end

    assign fault_reset = control_reg[dsm_pkg::CW_FAULT_RESET] && !fault_bit_reg;
    assign qs_exit = (cmd == dsm_pkg::CMD_DIS_VOLTAGE) || STOP_KEY || FREEWHEEL_STOP;
    assign ref_ready = !config_reg[dsm_pkg::CFG_REF_CHANNEL] || ref_seen_reg;
    assign ramp_run = (state_reg == dsm_pkg::ST_OPER_STOP)
        || (state_reg == dsm_pkg::ST_QUICK_STOP);

    dsm_ramp u_ramp
    (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .run(ramp_run),
        .fast(state_reg == dsm_pkg::ST_QUICK_STOP),
        .speed_in(speed_ref_reg),
        .done(ramp_done)
    );

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            dsm_pkg::ST_INIT:
                state_next = dsm_pkg::ST_SW_ON_DIS;
            dsm_pkg::ST_SW_ON_DIS:
                if (cmd == dsm_pkg::CMD_SHUTDOWN)
                    state_next = dsm_pkg::ST_READY;
            dsm_pkg::ST_READY:
                if (cmd == dsm_pkg::CMD_DIS_VOLTAGE || cmd == dsm_pkg::CMD_QUICK_STOP)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (cmd != dsm_pkg::CMD_SHUTDOWN && LINE_SUPPLY_OK)
                    state_next = dsm_pkg::ST_SWITCHED_ON;
            dsm_pkg::ST_SWITCHED_ON:
                if (cfg_wr || !LINE_SUPPLY_OK)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (cmd == dsm_pkg::CMD_DIS_VOLTAGE || cmd == dsm_pkg::CMD_QUICK_STOP)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (cmd == dsm_pkg::CMD_SHUTDOWN)
                    state_next = dsm_pkg::ST_READY;
                else if (cmd == dsm_pkg::CMD_ENABLE_OP && CHANNEL_VALID && ref_ready)
                    state_next = dsm_pkg::ST_OPER_EN;
            dsm_pkg::ST_OPER_EN:
                if (!LINE_SUPPLY_OK || FREEWHEEL_STOP || cmd == dsm_pkg::CMD_DIS_VOLTAGE)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (cmd == dsm_pkg::CMD_QUICK_STOP)
                    state_next = dsm_pkg::ST_QUICK_STOP;
                else if (cmd == dsm_pkg::CMD_SHUTDOWN)
                    state_next = dsm_pkg::ST_READY;
                else if (cmd == dsm_pkg::CMD_SWITCH_ON && !config_reg[dsm_pkg::CFG_DIS_OPT])
                    state_next = dsm_pkg::ST_SWITCHED_ON;
                else if (cmd == dsm_pkg::CMD_SWITCH_ON)
                    state_next = dsm_pkg::ST_OPER_STOP;
            dsm_pkg::ST_OPER_STOP:
                if (!LINE_SUPPLY_OK || FREEWHEEL_STOP || cmd == dsm_pkg::CMD_DIS_VOLTAGE)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (cmd == dsm_pkg::CMD_QUICK_STOP)
                    state_next = dsm_pkg::ST_QUICK_STOP;
                else if (ramp_done)
                    state_next = dsm_pkg::ST_SWITCHED_ON;
            dsm_pkg::ST_QUICK_STOP:
                if (qs_exit || !LINE_SUPPLY_OK)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
                else if (ramp_done && !config_reg[dsm_pkg::CFG_QS_HOLD])
                    state_next = dsm_pkg::ST_SW_ON_DIS;
            dsm_pkg::ST_FAULT:
                if (fault_reset)
                    state_next = dsm_pkg::ST_SW_ON_DIS;
            default:
                state_next = dsm_pkg::ST_SW_ON_DIS;
        endcase
        if (FAULT_DETECTED)
            state_next = dsm_pkg::ST_FAULT;
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_reg <= dsm_pkg::ST_INIT;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Auto-tuning.

    assign tune_start = wr_fire && reg_sel == dsm_pkg::REG_AUTOTUNE && AVS_WRITEDATA[0]
        && state_reg == dsm_pkg::ST_OPER_EN && !tune_busy_reg;

    // Leaving operation enabled aborts a run, since current can no longer be injected.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tune_busy_reg <= 1'b0;
            tune_cnt_reg <= 12'h000;
        end
        else if (tune_start)
        begin
            tune_busy_reg <= 1'b1;
            tune_cnt_reg <= 12'h000;
        end
        else if (tune_busy_reg)
        begin
            if (state_reg != dsm_pkg::ST_OPER_EN
                || tune_cnt_reg == 12'(dsm_pkg::TUNE_CYCLES - 1))
                tune_busy_reg <= 1'b0;
            tune_cnt_reg <= tune_cnt_reg + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            MOTOR_POWER <= 1'b0;
            DRIVE_UNLOCKED <= 1'b0;
            LINE_CONTACTOR <= 1'b0;
        end
        else
        begin
            MOTOR_POWER <= (state_reg == dsm_pkg::ST_OPER_EN && speed_ref_reg != 16'h0000
                && !control_reg[dsm_pkg::CW_HALT])
                || (ramp_run && !ramp_done);
            DRIVE_UNLOCKED <= state_reg == dsm_pkg::ST_OPER_EN || (ramp_run && !ramp_done);
            LINE_CONTACTOR <= config_reg[dsm_pkg::CFG_CONTACTOR]
                && (state_reg == dsm_pkg::ST_SWITCHED_ON || state_reg == dsm_pkg::ST_OPER_EN
                || ramp_run);
        end
    end

    // The initialization state is shown as switch-on-disabled.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_word_reg <= dsm_pkg::SW_SW_ON_DIS;
        else
        begin
            case (state_reg)
                dsm_pkg::ST_READY: state_word_reg <= dsm_pkg::SW_READY;
                dsm_pkg::ST_SWITCHED_ON: state_word_reg <= dsm_pkg::SW_SWITCHED_ON;
                dsm_pkg::ST_OPER_EN: state_word_reg <= dsm_pkg::SW_OPER_EN;
                dsm_pkg::ST_OPER_STOP: state_word_reg <= dsm_pkg::SW_OPER_EN;
                dsm_pkg::ST_QUICK_STOP: state_word_reg <= dsm_pkg::SW_QUICK_STOP;
                dsm_pkg::ST_FAULT: state_word_reg <= dsm_pkg::SW_FAULT;
                default: state_word_reg <= dsm_pkg::SW_SW_ON_DIS;
            endcase
        end
    end

    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA = rdata_reg;
    assign AUTOTUNE_ACTIVE = tune_busy_reg;
    assign STATE_WORD = state_word_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence ready_to_on_s;
        state_reg == dsm_pkg::ST_READY ##1 state_reg == dsm_pkg::ST_SWITCHED_ON;
    endsequence

    sequence on_to_enabled_s;
        state_reg == dsm_pkg::ST_SWITCHED_ON ##1 state_reg == dsm_pkg::ST_OPER_EN;
    endsequence

    init_hidden_a: assert property (state_reg == dsm_pkg::ST_INIT
        |=> STATE_WORD == dsm_pkg::SW_SW_ON_DIS)
        else $error("Initialization state was reported.");
    init_exit_a: assert property (state_reg == dsm_pkg::ST_INIT && !FAULT_DETECTED
        |=> state_reg == dsm_pkg::ST_SW_ON_DIS)
        else $error("Initialization did not end in switch-on-disabled.");
    disabled_safe_a: assert property (state_reg == dsm_pkg::ST_SW_ON_DIS
        |=> !MOTOR_POWER && !LINE_CONTACTOR && !DRIVE_UNLOCKED)
        else $error("Switch-on-disabled left power or contactor on.");
    ready_supply_a: assert property (ready_to_on_s |-> $past(LINE_SUPPLY_OK))
        else $error("Switched on without line supply.");
    on_contactor_a: assert property (state_reg == dsm_pkg::ST_SWITCHED_ON
        |=> LINE_CONTACTOR == $past(config_reg[dsm_pkg::CFG_CONTACTOR]) && !MOTOR_POWER)
        else $error("Switched-on outputs wrong.");
    cfg_return_a: assert property (state_reg == dsm_pkg::ST_SWITCHED_ON && cfg_wr
        && !FAULT_DETECTED |=> state_reg == dsm_pkg::ST_SW_ON_DIS)
        else $error("Configuration write did not return to disabled.");
    cfg_locked_a: assert property (state_reg == dsm_pkg::ST_OPER_EN && cfg_wr
        |=> $stable(cfg_param_reg))
        else $error("Configuration changed while operation enabled.");
    zero_ref_a: assert property (state_reg == dsm_pkg::ST_OPER_EN
        && (speed_ref_reg == 16'h0000 || control_reg[dsm_pkg::CW_HALT]) |=> !MOTOR_POWER)
        else $error("Motor powered with zero reference or halt.");
    tune_state_a: assert property (tune_start |-> state_reg == dsm_pkg::ST_OPER_EN
        ##1 AUTOTUNE_ACTIVE)
        else $error("Auto-tuning started outside operation enabled.");
    enable_gate_a: assert property (on_to_enabled_s
        |-> $past(CHANNEL_VALID) && $past(ref_ready))
        else $error("Operation enabled without valid channel or reference.");
    coast_stop_a: assert property (state_reg == dsm_pkg::ST_OPER_EN && !FAULT_DETECTED
        && LINE_SUPPLY_OK && !FREEWHEEL_STOP && cmd == dsm_pkg::CMD_SWITCH_ON
        && !config_reg[dsm_pkg::CFG_DIS_OPT] |=> state_reg == dsm_pkg::ST_SWITCHED_ON)
        else $error("Disable option zero did not coast to switched-on.");
    ramp_stop_a: assert property (state_reg == dsm_pkg::ST_OPER_STOP && ramp_done
        && !FAULT_DETECTED && LINE_SUPPLY_OK && !FREEWHEEL_STOP
        && cmd == dsm_pkg::CMD_SWITCH_ON |=> state_reg == dsm_pkg::ST_SWITCHED_ON)
        else $error("Ramp stop did not end in switched-on.");
    qs_restart_a: assert property (state_reg == dsm_pkg::ST_QUICK_STOP
        |=> state_reg inside {dsm_pkg::ST_QUICK_STOP, dsm_pkg::ST_SW_ON_DIS,
        dsm_pkg::ST_FAULT})
        else $error("Quick stop left without passing switch-on-disabled.");
    qs_auto_exit_a: assert property (state_reg == dsm_pkg::ST_QUICK_STOP && ramp_done
        && !config_reg[dsm_pkg::CFG_QS_HOLD] && !FAULT_DETECTED
        |=> state_reg == dsm_pkg::ST_SW_ON_DIS)
        else $error("Auto-exit quick stop did not move to disabled.");
    qs_hold_a: assert property (state_reg == dsm_pkg::ST_QUICK_STOP && ramp_done
        && config_reg[dsm_pkg::CFG_QS_HOLD] && !qs_exit && LINE_SUPPLY_OK && !FAULT_DETECTED
        |=> state_reg == dsm_pkg::ST_QUICK_STOP)
        else $error("Hold quick stop left without an exit event.");
    report_a: assert property (state_reg == dsm_pkg::ST_QUICK_STOP
        |=> STATE_WORD == dsm_pkg::SW_QUICK_STOP)
        else $error("Status word does not match quick stop.");
    fault_lock_a: assert property (state_reg == dsm_pkg::ST_FAULT && !fault_reset
        |=> state_reg == dsm_pkg::ST_FAULT ##1 !MOTOR_POWER)
        else $error("Fault left without a fault reset.");

endmodule

/* File: dsm_master.sv */
// Bus master model standing in for the network master.
`timescale 1ns/1ps
module dsm_master
(
    input wire logic clk,
    output logic [4:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    // Command words sent by the master.
    localparam logic [15:0] SHUTDOWN = 16'h0006;
    localparam logic [15:0] SWITCH_ON = 16'h0007;
    localparam logic [15:0] ENABLE_OP = 16'h000F;
    localparam logic [15:0] QUICK_STOP = 16'h0002;
    initial
    begin
        {address, read, write, writedata} = '0;
        byteenable = 4'hF;
    end
    // The request is held until waitrequest is seen low at an edge.
    task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] r, input logic [31:0] d);
        logic [31:0] q;
        xfer({r, 2'b00}, 1'b1, d, q);
    endtask
endmodule

/* File: drive_state_machine_bench.sv */
// Self-checking bench for the drive sequencing state machine.
`timescale 1ns/1ps
module drive_state_machine_bench;
    logic clk = 0, rst_n = 0, line_ok = 0, chan_ok = 0, stop_in = 0, flt = 0;
    logic [4:0] adr;
    logic rd, wrq, wt, mp, lc, ul, at;
    logic [31:0] wd, rdat, q;
    logic [3:0] be;
    logic [15:0] sw;
    int error_cnt = 0, compares = 0, cyc = 0;
    always #20 clk = ~clk;
    dsm_master i_master (.clk(clk), .address(adr), .read(rd), .write(wrq),
        .writedata(wd), .byteenable(be), .readdata(rdat), .waitrequest(wt));
    dsm_top i_dut (.REF_CLK(clk), .RSTN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wrq), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wt), .LINE_SUPPLY_OK(line_ok), .CHANNEL_VALID(chan_ok),
        .STOP_KEY(stop_in), .FREEWHEEL_STOP(stop_in), .FAULT_DETECTED(flt),
        .MOTOR_POWER(mp), .LINE_CONTACTOR(lc), .DRIVE_UNLOCKED(ul),
        .AUTOTUNE_ACTIVE(at), .STATE_WORD(sw));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Bounded wait, since the state word trails the command by a few cycles.
    task automatic wait_sw(input logic [15:0] e);
        for (int i = 0; i < 400 && sw !== e; i++) @(negedge clk);
        chk(sw, e);
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up;
        @(negedge clk);
        chk(sw, 16'h0040);
        chk({mp, lc, ul}, 3'h0);
        i_master.xfer(5'h1C, 1'b0, 0, q);
        chk(q[15:0], 16'h0000);
        i_master.xfer(5'h04, 1'b0, 0, q);
        chk(q[15:0], 16'h0040);
        $display("power up done");
    endtask
    task automatic t_start(input logic [31:0] cfg);
        @(posedge clk);
        line_ok <= 1'b0;
        chan_ok <= 1'b0;
        i_master.wr(dsm_pkg::REG_CONFIG, cfg);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.SHUTDOWN);
        wait_sw(16'h0021);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.SWITCH_ON);
        repeat (5) @(negedge clk);
        chk(sw, 16'h0021);
        @(posedge clk);
        line_ok <= 1'b1;
        wait_sw(16'h0023);
        chk({mp, lc}, 2'b01);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.ENABLE_OP);
        repeat (5) @(negedge clk);
        chk(sw, 16'h0023);
        @(posedge clk);
        chan_ok <= 1'b1;
        wait_sw(16'h0027);
        i_master.wr(dsm_pkg::REG_SPEED_REF, 32'h0000_0000);
        repeat (3) @(negedge clk);
        chk({mp, ul}, 2'b01);
        i_master.wr(dsm_pkg::REG_SPEED_REF, 32'h0000_0100);
        repeat (3) @(negedge clk);
        chk({mp, ul}, 2'b11);
        i_master.wr(dsm_pkg::REG_CONTROL, 32'h0000_010F);
        repeat (3) @(negedge clk);
        chk({mp, sw}, {1'b0, 16'h0027});
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.ENABLE_OP);
        $display("start done");
    endtask
    task automatic t_coast_and_config;
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.SWITCH_ON);
        repeat (3) @(negedge clk);
        chk({mp, sw}, {1'b0, 16'h0023});
        i_master.wr(dsm_pkg::REG_CFG_PARAM, 32'h0000_0001);
        wait_sw(16'h0040);
        $display("coast done");
    endtask
    task automatic t_quick_stop;
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.QUICK_STOP);
        repeat (3) @(negedge clk);
        chk({mp, sw}, {1'b1, 16'h0007});
        wait_sw(16'h0040);
        $display("quick stop done");
    endtask
    // Ramp stop aborts a tuning run; hold quick stop needs an exit event.
    task automatic t_ramp_hold;
        i_master.wr(dsm_pkg::REG_AUTOTUNE, 32'h0000_0001);
        repeat (3) @(negedge clk);
        chk(at, 1'b1);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.SWITCH_ON);
        repeat (3) @(negedge clk);
        chk({mp, sw}, {1'b1, 16'h0027});
        chk(at, 1'b0);
        wait_sw(16'h0023);
        chk(mp, 1'b0);
        i_master.wr(dsm_pkg::REG_AUTOTUNE, 32'h0000_0001);
        repeat (3) @(negedge clk);
        chk(at, 1'b0);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.ENABLE_OP);
        wait_sw(16'h0027);
        i_master.wr(dsm_pkg::REG_CONTROL, i_master.QUICK_STOP);
        repeat (40) @(negedge clk);
        chk({mp, sw}, {1'b0, 16'h0007});
        @(posedge clk);
        stop_in <= 1'b1;
        wait_sw(16'h0040);
        @(posedge clk);
        stop_in <= 1'b0;
        flt <= 1'b1;
        wait_sw(16'h0008);
        @(posedge clk);
        flt <= 1'b0;
        repeat (3) @(negedge clk);
        chk({mp, sw}, {1'b0, 16'h0008});
        i_master.wr(dsm_pkg::REG_CONTROL, 32'h0000_0080);
        wait_sw(16'h0040);
        $display("ramp hold fault done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_start(32'h0000_0004);
        t_coast_and_config();
        t_start(32'h0000_0004);
        t_quick_stop();
        t_start(32'h0000_0007);
        t_ramp_hold();
        end_sim();
    end
endmodule
